// File: rtl/tvf_filter.sv
/*
  tvf_filter: per-frame egress decision for a multi-port switch with one trunk
  group, workgroups (bridge mode), port vlans (tagged mode) and a small
  learned address table with aging. registers are reached over apb.
  assumes frame descriptors arrive on pclk, one per frm_valid pulse, with
  crc checks already done upstream.
*/
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - one trunk, three slower ports at most
// - known trunk unicast spread over members
// - flooded traffic uses one trunk member
// - trunk entries never age, port updates
// - trunk ingress never egresses same trunk
// - trunk per port, readable by software
// - eight workgroups, overlapping port sets
// - workgroups only in bridge mode
// - workgroup confines broadcast and unicast
// - tagged mode: vlan members, forwarding ports
// - ingress drops or passes every frame
// - flag crc rebuild, no queues or priority
// - dynamic vlans only from registration frames
// - egress members only, per-port tag strip
// - thirty-two vlans at most
// - one global mode, bridge after reset
// - per-port default vlan, resets to one
// - registration enabled per port
// - blocked ids never dynamically registered
// - same aging time in both modes
// - access ports strip the tag in tagged mode only
// - erase restores all settings to defaults but selects and vlan/block ids
// - idle non-trunk entries age out
// - unknown destinations flood eligible ports
module tvf_filter #(
  parameter int NPORTS = 8,
  parameter int TBL = 16,
  parameter logic [31:0] DUAL_RATE_MASK = 32'h0000_003F,
  parameter longint TICK_CYCLES = tvf_pkg::AGE_TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // frame descriptor in
  input wire logic frm_valid,
  input wire logic [$clog2(NPORTS)-1:0] frm_src_port,
  input wire logic [47:0] frm_dst_mac,
  input wire logic [47:0] frm_src_mac,
  input wire logic frm_tagged,
  input wire logic [11:0] frm_vid,
  input wire logic frm_gvrp,
  // forwarding decision out
  output logic fwd_valid,
  output logic [NPORTS-1:0] fwd_ports,
  output logic [NPORTS-1:0] fwd_strip,
  output logic fwd_drop,
  output logic fwd_fcs_recalc
);
  localparam int PW = $clog2(NPORTS);
  localparam int TW = $clog2(TBL);
  localparam logic [NPORTS-1:0] DUAL = DUAL_RATE_MASK[NPORTS-1:0];

  function automatic logic [5:0] ones(input logic [NPORTS-1:0] m);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < NPORTS; i++) c = c + {5'h00, m[i]};
    return c;
  endfunction

  function automatic logic [NPORTS-1:0] nth_member(input logic [NPORTS-1:0] m,
                                                   input logic [1:0] k);
    logic [NPORTS-1:0] r;
    logic [1:0] n;
    r = '0;
    n = 2'h0;
    for (int i = 0; i < NPORTS; i++) begin
      if (m[i]) begin
        if (n == k) r[i] = 1'b1;
        n = n + 2'h1;
      end
    end
    return r;
  endfunction

  // configuration
  logic mode;
  logic [NPORTS-1:0] trunk_mask, access_mask, gvrp_mask, stp_fwd;
  logic [15:0] age_s;
  logic [2:0] wg_sel;
  logic [4:0] vl_sel;
  logic [PW-1:0] pv_sel;
  logic [2:0] bl_sel;
  logic [NPORTS-1:0] wg_ports [tvf_pkg::NUM_WG];
  logic [11:0] vl_id [tvf_pkg::NUM_VLAN];
  logic [tvf_pkg::NUM_VLAN-1:0] vl_valid, vl_dyn;
  logic [NPORTS-1:0] vl_ports [tvf_pkg::NUM_VLAN];
  logic [11:0] pvid [NPORTS];
  logic [11:0] bl_id [tvf_pkg::NUM_BLOCK];
  logic [tvf_pkg::NUM_BLOCK-1:0] bl_valid;

  // apb decode
  logic apb_wr, apb_rd, erase;
  assign apb_wr = psel & penable & pready & pwrite;
  assign apb_rd = psel & penable & ~pready;
  assign erase = apb_wr && paddr == tvf_pkg::OFF_CTRL && pwdata[tvf_pkg::CTRL_ERASE_BIT];

  // address table
  logic [TBL-1:0] tb_valid, tb_trunk;
  logic [47:0] tb_mac [TBL];
  logic [PW-1:0] tb_port [TBL];
  logic [15:0] tb_age [TBL];
  logic dst_hit, src_hit, free_hit, dst_trk;
  logic [PW-1:0] dst_port;
  logic [TW-1:0] src_idx, free_idx;

  always_comb begin
    dst_hit = 1'b0;
    dst_trk = 1'b0;
    dst_port = '0;
    src_hit = 1'b0;
    src_idx = '0;
    free_hit = 1'b0;
    free_idx = '0;
    for (int i = 0; i < TBL; i++) begin
      if (tb_valid[i] && tb_mac[i] == frm_dst_mac) begin
        dst_hit = 1'b1;
        dst_trk = tb_trunk[i];
        dst_port = tb_port[i];
      end
      if (tb_valid[i] && tb_mac[i] == frm_src_mac) begin
        src_hit = 1'b1;
        src_idx = TW'(i);
      end
      if (!tb_valid[i]) begin
        free_hit = 1'b1;
        free_idx = TW'(i);
      end
    end
  end

  // vlan classification and lookups
  logic [11:0] vid_c;
  logic v_hit, v_free_hit, blk_hit;
  logic [4:0] v_idx, v_free;
  always_comb begin
    vid_c = frm_tagged ? frm_vid : pvid[frm_src_port];
    v_hit = 1'b0;
    v_idx = 5'h00;
    v_free_hit = 1'b0;
    v_free = 5'h00;
    blk_hit = 1'b0;
    for (int i = 0; i < tvf_pkg::NUM_VLAN; i++) begin
      if (vl_valid[i] && vl_id[i] == vid_c) begin
        v_hit = 1'b1;
        v_idx = 5'(i);
      end
      if (!vl_valid[i]) begin
        v_free_hit = 1'b1;
        v_free = 5'(i);
      end
    end
    for (int i = 0; i < tvf_pkg::NUM_BLOCK; i++) begin
      if (bl_valid[i] && bl_id[i] == frm_vid) blk_hit = 1'b1;
    end
  end

  logic gvrp_ok;
  assign gvrp_ok = frm_valid && frm_gvrp && mode && gvrp_mask[frm_src_port] && !blk_hit;

  // configuration registers; apb wins over a registration in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= tvf_pkg::RST_MODE;
      trunk_mask <= '0;
      access_mask <= '0;
      gvrp_mask <= '0;
      stp_fwd <= '1;
      age_s <= tvf_pkg::RST_AGE_S;
      wg_sel <= 3'h0;
      vl_sel <= 5'h00;
      pv_sel <= '0;
      bl_sel <= 3'h0;
      vl_valid <= '0;
      vl_dyn <= '0;
      bl_valid <= '0;
      for (int i = 0; i < tvf_pkg::NUM_WG; i++) wg_ports[i] <= '0;
      for (int i = 0; i < tvf_pkg::NUM_VLAN; i++) begin
        vl_id[i] <= 12'h000;
        vl_ports[i] <= '0;
      end
      for (int i = 0; i < NPORTS; i++) pvid[i] <= tvf_pkg::RST_PVID;
      for (int i = 0; i < tvf_pkg::NUM_BLOCK; i++) bl_id[i] <= 12'h000;
    end else if (erase) begin
      // erase returns every setting to default except the select registers and the vlan and block ids
      mode <= tvf_pkg::RST_MODE;
      trunk_mask <= '0;
      access_mask <= '0;
      gvrp_mask <= '0;
      stp_fwd <= '1;
      age_s <= tvf_pkg::RST_AGE_S;
      vl_valid <= '0;
      vl_dyn <= '0;
      bl_valid <= '0;
      for (int i = 0; i < tvf_pkg::NUM_WG; i++) wg_ports[i] <= '0;
      for (int i = 0; i < tvf_pkg::NUM_VLAN; i++) vl_ports[i] <= '0;
      // default vlan one on every port
      for (int i = 0; i < NPORTS; i++) pvid[i] <= tvf_pkg::RST_PVID;
    end else if (apb_wr) begin
      case (paddr)
        tvf_pkg::OFF_CTRL: mode <= pwdata[tvf_pkg::CTRL_MODE_BIT];
        // oversize or full-rate trunk writes are ignored
        tvf_pkg::OFF_TRUNK: begin
          if ((pwdata[NPORTS-1:0] & ~DUAL) == '0 &&
              ones(pwdata[NPORTS-1:0]) <= 6'(tvf_pkg::TRUNK_MAX)) begin
            trunk_mask <= pwdata[NPORTS-1:0];
          end
        end
        tvf_pkg::OFF_ACCESS: access_mask <= pwdata[NPORTS-1:0];
        tvf_pkg::OFF_GVRP: gvrp_mask <= pwdata[NPORTS-1:0];
        // one aging time for both modes
        tvf_pkg::OFF_AGE: age_s <= pwdata[15:0];
        tvf_pkg::OFF_WG_SEL: wg_sel <= pwdata[2:0];
        tvf_pkg::OFF_WG_PORTS: wg_ports[wg_sel] <= pwdata[NPORTS-1:0];
        tvf_pkg::OFF_VL_SEL: vl_sel <= pwdata[4:0];
        // static entries in the 32-slot table
        tvf_pkg::OFF_VL_ID: begin
          vl_id[vl_sel] <= pwdata[11:0];
          vl_valid[vl_sel] <= pwdata[tvf_pkg::VL_VALID_BIT];
          vl_dyn[vl_sel] <= 1'b0;
        end
        tvf_pkg::OFF_VL_PORTS: vl_ports[vl_sel] <= pwdata[NPORTS-1:0];
        tvf_pkg::OFF_PV_SEL: pv_sel <= pwdata[PW-1:0];
        tvf_pkg::OFF_PV_ID: pvid[pv_sel] <= pwdata[11:0];
        tvf_pkg::OFF_BL_SEL: bl_sel <= pwdata[2:0];
        tvf_pkg::OFF_BL_ID: begin
          bl_id[bl_sel] <= pwdata[11:0];
          bl_valid[bl_sel] <= pwdata[tvf_pkg::BL_VALID_BIT];
        end
        tvf_pkg::OFF_STP_FWD: stp_fwd <= pwdata[NPORTS-1:0];
        default: ;
      endcase
    end else if (gvrp_ok) begin
      // matching entry joined, or dynamic entry created, by registration
      if (v_hit) begin
        vl_ports[v_idx][frm_src_port] <= 1'b1;
      end else if (v_free_hit) begin
        vl_id[v_free] <= frm_vid;
        vl_valid[v_free] <= 1'b1;
        vl_dyn[v_free] <= 1'b1;
        vl_ports[v_free] <= NPORTS'(1) << frm_src_port;
      end
    end
  end

  // aging tick
  logic [39:0] tick_cnt;
  logic tick;
  assign tick = tick_cnt == 40'(TICK_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt <= 40'h00_0000_0000;
    else if (tick) tick_cnt <= 40'h00_0000_0000;
    else tick_cnt <= tick_cnt + 40'h00_0000_0001;
  end

  // learning and aging
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_valid <= '0;
      tb_trunk <= '0;
      for (int i = 0; i < TBL; i++) begin
        tb_mac[i] <= 48'h0000_0000_0000;
        tb_port[i] <= '0;
        tb_age[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < TBL; i++) begin
        // idle entries expire unless trunk bound
        if (tick && tb_valid[i] && !tb_trunk[i]) begin
          if (tb_age[i] + 16'h0001 >= age_s) tb_valid[i] <= 1'b0;
          else tb_age[i] <= tb_age[i] + 16'h0001;
        end
      end
      if (frm_valid && !frm_src_mac[40]) begin
        if (src_hit) begin
          // trunk entry may still move port
          tb_port[src_idx] <= frm_src_port;
          tb_trunk[src_idx] <= trunk_mask[frm_src_port];
          tb_age[src_idx] <= 16'h0000;
          tb_valid[src_idx] <= 1'b1;
        end else if (free_hit) begin
          tb_valid[free_idx] <= 1'b1;
          tb_mac[free_idx] <= frm_src_mac;
          tb_port[free_idx] <= frm_src_port;
          tb_trunk[free_idx] <= trunk_mask[frm_src_port];
          tb_age[free_idx] <= 16'h0000;
        end
      end
    end
  end

  // forwarding decision
  logic [7:0] hash8;
  logic [1:0] pick_k;
  logic [NPORTS-1:0] pick, base, wg_allow, egress, next_strip;
  logic src_trunk, flood, in_drop;
  always_comb begin
    // member fixed by the address pair
    hash8 = frm_dst_mac[7:0] ^ frm_src_mac[7:0] ^ frm_dst_mac[47:40] ^ frm_src_mac[47:40];
    case (ones(trunk_mask))
      6'h02: pick_k = {1'b0, hash8[0]};
      6'h03: pick_k = 2'(hash8 % 8'h03);
      default: pick_k = 2'h0;
    endcase
    pick = nth_member(trunk_mask, pick_k);
    src_trunk = trunk_mask[frm_src_port];
    flood = !dst_hit || frm_dst_mac[40];
    base = ~(NPORTS'(1) << frm_src_port);
    // tagged mode limited to forwarding ports
    if (mode) base = base & stp_fwd;
    wg_allow = '0;
    for (int i = 0; i < tvf_pkg::NUM_WG; i++) begin
      if (wg_ports[i][frm_src_port]) wg_allow = wg_allow | wg_ports[i];
    end
    // workgroups only bind in bridge mode
    if (!mode && wg_allow != '0) base = base & wg_allow;
    // no echo back into the trunk
    if (src_trunk) base = base & ~trunk_mask;
    if (flood) begin
      egress = (base & ~trunk_mask) | (base & pick);
    end else if (dst_trk && trunk_mask[dst_port]) begin
      egress = base & pick;
    end else begin
      egress = base & (NPORTS'(1) << dst_port);
    end
    // tagged ingress: known vlan, member source
    in_drop = mode && (!v_hit || !vl_ports[v_idx][frm_src_port]);
    if (mode) egress = egress & vl_ports[v_idx];
    if (in_drop) egress = '0;
    // in tagged mode access ports strip, others keep tag
    next_strip = mode ? access_mask : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_valid <= 1'b0;
      fwd_ports <= '0;
      fwd_strip <= '0;
      fwd_drop <= 1'b0;
      fwd_fcs_recalc <= 1'b0;
    end else begin
      fwd_valid <= frm_valid;
      fwd_ports <= frm_valid ? egress : '0;
      fwd_strip <= next_strip;
      fwd_drop <= frm_valid && egress == '0;
      // crc rebuilt when a tag is added or removed
      fwd_fcs_recalc <= frm_valid && mode &&
                        ((egress & (frm_tagged ? access_mask : ~access_mask)) != '0);
    end
  end

  // apb response: one wait state, errors on unmapped offsets
  logic [31:0] next_prdata;
  logic next_err;
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      tvf_pkg::OFF_CTRL: next_prdata[tvf_pkg::CTRL_MODE_BIT] = mode;
      tvf_pkg::OFF_TRUNK: next_prdata[NPORTS-1:0] = trunk_mask;
      tvf_pkg::OFF_ACCESS: next_prdata[NPORTS-1:0] = access_mask;
      tvf_pkg::OFF_GVRP: next_prdata[NPORTS-1:0] = gvrp_mask;
      tvf_pkg::OFF_AGE: next_prdata[15:0] = age_s;
      tvf_pkg::OFF_WG_SEL: next_prdata[2:0] = wg_sel;
      tvf_pkg::OFF_WG_PORTS: next_prdata[NPORTS-1:0] = wg_ports[wg_sel];
      tvf_pkg::OFF_VL_SEL: next_prdata[4:0] = vl_sel;
      tvf_pkg::OFF_VL_ID: begin
        next_prdata[11:0] = vl_id[vl_sel];
        next_prdata[tvf_pkg::VL_VALID_BIT] = vl_valid[vl_sel];
        next_prdata[tvf_pkg::VL_DYN_BIT] = vl_dyn[vl_sel];
      end
      tvf_pkg::OFF_VL_PORTS: next_prdata[NPORTS-1:0] = vl_ports[vl_sel];
      tvf_pkg::OFF_PV_SEL: next_prdata[PW-1:0] = pv_sel;
      tvf_pkg::OFF_PV_ID: next_prdata[11:0] = pvid[pv_sel];
      tvf_pkg::OFF_BL_SEL: next_prdata[2:0] = bl_sel;
      tvf_pkg::OFF_BL_ID: begin
        next_prdata[11:0] = bl_id[bl_sel];
        next_prdata[tvf_pkg::BL_VALID_BIT] = bl_valid[bl_sel];
      end
      tvf_pkg::OFF_STP_FWD: next_prdata[NPORTS-1:0] = stp_fwd;
      tvf_pkg::OFF_STATUS: next_prdata[5:0] = 6'(ones(NPORTS'(0)) + 6'($countones(tb_valid)));
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_rd;
      prdata <= apb_rd && !pwrite ? next_prdata : 32'h0000_0000;
      pslverr <= apb_rd && next_err;
    end
  end

  // checks
  chk_erase_defaults: assert property (@(posedge pclk) disable iff (!presetn)
    erase |=> !mode && pvid[0] == tvf_pkg::RST_PVID && trunk_mask == '0)
    else $error("erase did not restore defaults");

  chk_trunk_no_echo: assert property (@(posedge pclk) disable iff (!presetn)
    frm_valid && trunk_mask[frm_src_port] |=> (fwd_ports & $past(trunk_mask)) == '0)
    else $error("trunk ingress frame sent back into trunk");

  chk_trunk_one_flood: assert property (@(posedge pclk) disable iff (!presetn)
    frm_valid && flood |=> $countones(fwd_ports & $past(trunk_mask)) <= 1)
    else $error("flooded frame used more than one trunk member");

  chk_ingress_drop: assert property (@(posedge pclk) disable iff (!presetn)
    frm_valid && mode && !v_hit |=> fwd_drop && fwd_ports == '0)
    else $error("frame of unknown vlan not dropped");

  chk_access_strip: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_valid && $past(mode) |-> (fwd_strip & $past(access_mask)) == $past(access_mask))
    else $error("access port kept its tag");

  chk_trunk_limit: assert property (@(posedge pclk) disable iff (!presetn)
    $countones(trunk_mask) <= 3 && (trunk_mask & ~DUAL) == '0)
    else $error("trunk group exceeds its limits");

  // counter restarts after a tick and does not tick again at once
  sequence tick_restart;
    tick_cnt == 40'h00_0000_0000 ##1 (!tick || TICK_CYCLES == 1);
  endsequence

  chk_age_tick: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> tick_restart)
    else $error("aging tick counter misbehaves");

  chk_gvrp_block: assert property (@(posedge pclk) disable iff (!presetn)
    frm_valid && frm_gvrp && blk_hit && !apb_wr && !erase |=> $stable(vl_valid))
    else $error("blocked vlan id was registered");
endmodule // tvf_filter
`default_nettype wire

// File: rtl/tvf_pkg.sv
/*
  tvf_pkg: constants for the trunk / workgroup / vlan forwarding filter.
  assumes a 100 MHz pclk and a 32-bit apb register bus.
*/
package tvf_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TRUNK = 8'h04;
  localparam logic [7:0] OFF_ACCESS = 8'h08;
  localparam logic [7:0] OFF_GVRP = 8'h0C;
  localparam logic [7:0] OFF_AGE = 8'h10;
  localparam logic [7:0] OFF_WG_SEL = 8'h14;
  localparam logic [7:0] OFF_WG_PORTS = 8'h18;
  localparam logic [7:0] OFF_VL_SEL = 8'h1C;
  localparam logic [7:0] OFF_VL_ID = 8'h20;
  localparam logic [7:0] OFF_VL_PORTS = 8'h24;
  localparam logic [7:0] OFF_PV_SEL = 8'h28;
  localparam logic [7:0] OFF_PV_ID = 8'h2C;
  localparam logic [7:0] OFF_BL_SEL = 8'h30;
  localparam logic [7:0] OFF_BL_ID = 8'h34;
  localparam logic [7:0] OFF_STP_FWD = 8'h38;
  localparam logic [7:0] OFF_STATUS = 8'h3C;
  // field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_ERASE_BIT = 1;
  localparam int VL_VALID_BIT = 12;
  localparam int VL_DYN_BIT = 13;
  localparam int BL_VALID_BIT = 12;
  // sizes
  localparam int NUM_WG = 8;
  localparam int NUM_VLAN = 32;
  localparam int NUM_BLOCK = 8;
  localparam int TRUNK_MAX = 3;
  // values after reset or erase
  localparam logic RST_MODE = 1'b0;
  localparam logic [11:0] RST_PVID = 12'h001;
  localparam logic [15:0] RST_AGE_S = 16'h012C;
  // timing: one aging tick per second
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint AGE_TICK_NS = 1000000000;
  localparam longint AGE_TICK_CYCLES = AGE_TICK_NS / CLK_PERIOD_NS;
endpackage

// File: testbench/tvf_seg_model.sv
/*
  tvf_seg_model: the attached segments, issuing one frame descriptor per send.
  assumes the bench raises send for one pclk cycle with the fields held.
*/
`timescale 1ns/1ns
`default_nettype none
module tvf_seg_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench request
  input wire logic send,
  input wire logic [2:0] s_port,
  input wire logic [47:0] s_dst,
  input wire logic s_tag,
  input wire logic [11:0] s_vid,
  input wire logic s_gvrp,
  // descriptor to the filter
  output logic frm_valid,
  output logic [2:0] frm_src_port,
  output logic [47:0] frm_dst_mac,
  output logic [47:0] frm_src_mac,
  output logic frm_tagged,
  output logic [11:0] frm_vid,
  output logic frm_gvrp
);
  // idle mac and vid fields flip every cycle so stale values never pass for a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frm_valid <= 1'b0;
      {frm_src_port, frm_dst_mac, frm_src_mac, frm_tagged, frm_vid, frm_gvrp} <= '0;
    end else if (send) begin
      frm_valid <= 1'b1;
      {frm_src_port, frm_dst_mac, frm_tagged, frm_vid, frm_gvrp} <=
        {s_port, s_dst, s_tag, s_vid, s_gvrp};
      frm_src_mac <= {8'h02, 37'h0, s_port};
    end else begin
      frm_valid <= 1'b0;
      {frm_dst_mac, frm_src_mac, frm_vid} <= ~{frm_dst_mac, frm_src_mac, frm_vid};
    end
  end
endmodule // tvf_seg_model
`default_nettype wire

// File: testbench/tvf_filter_tb_top.sv
/*
  tvf_filter_tb_top: directed bench for the forwarding filter.
  assumes the three-cycle apb access (one wait state) and the one-cycle frame answer.
*/
`timescale 1ns/1ns
`default_nettype none
module tvf_filter_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, send = 1'b0, s_tag = 1'b0, s_gvrp = 1'b0;
  logic [2:0] s_port = 3'h0, frm_src_port;
  logic [47:0] s_dst = 48'h0, frm_dst_mac, frm_src_mac;
  logic [11:0] s_vid = 12'h000, frm_vid;
  logic frm_valid, frm_tagged, frm_gvrp, fwd_valid, fwd_drop, fwd_fcs_recalc, g_drop, g_fcs;
  logic [7:0] fwd_ports, fwd_strip, g_ports, g_strip, first;
  int fail_count = 0, n_compared = 0, lat;
  localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
  // short aging tick keeps timed behaviour reachable
  tvf_filter #(.TICK_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frm_valid(frm_valid), .frm_src_port(frm_src_port),
    .frm_dst_mac(frm_dst_mac), .frm_src_mac(frm_src_mac), .frm_tagged(frm_tagged),
    .frm_vid(frm_vid), .frm_gvrp(frm_gvrp), .fwd_valid(fwd_valid), .fwd_ports(fwd_ports),
    .fwd_strip(fwd_strip), .fwd_drop(fwd_drop), .fwd_fcs_recalc(fwd_fcs_recalc));
  tvf_seg_model seg (.pclk(pclk), .presetn(presetn), .send(send), .s_port(s_port),
    .s_dst(s_dst), .s_tag(s_tag), .s_vid(s_vid), .s_gvrp(s_gvrp), .frm_valid(frm_valid),
    .frm_src_port(frm_src_port), .frm_dst_mac(frm_dst_mac), .frm_src_mac(frm_src_mac),
    .frm_tagged(frm_tagged), .frm_vid(frm_vid), .frm_gvrp(frm_gvrp));
  initial begin
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin fail_count++; end_of_test(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  task automatic frame(input logic [2:0] p, input logic [47:0] d, input logic t,
                       input logic [11:0] v, input logic gv);
    @(posedge pclk);
    send <= 1'b1; s_port <= p; s_dst <= d; s_tag <= t; s_vid <= v; s_gvrp <= gv;
    @(posedge pclk);
    send <= 1'b0;
    lat = 0;
    do begin @(posedge pclk); lat++; end while (fwd_valid !== 1'b1 && lat < 4);
    if (fwd_valid !== 1'b1) begin fail_count++; end_of_test(); end
    {g_ports, g_strip, g_drop, g_fcs} = {fwd_ports, fwd_strip, fwd_drop, fwd_fcs_recalc};
  endtask
  task automatic t_reset();
    rdc("mode", tvf_pkg::OFF_CTRL, 32'h0);
    rdc("age", tvf_pkg::OFF_AGE, 32'h0000_012C);
    rdc("pvid", tvf_pkg::OFF_PV_ID, 32'h0000_0001);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", err, 32'h1);
    $display("reset done");
  endtask
  task automatic t_trunk();
    wr(tvf_pkg::OFF_TRUNK, 32'h07);
    rdc("trunk", tvf_pkg::OFF_TRUNK, 32'h07);
    wr(tvf_pkg::OFF_TRUNK, 32'hC0);
    rdc("trunk fast", tvf_pkg::OFF_TRUNK, 32'h07);
    wr(tvf_pkg::OFF_TRUNK, 32'h0F);
    rdc("trunk four", tvf_pkg::OFF_TRUNK, 32'h07);
    frame(3'h0, BC, 1'b0, 12'h000, 1'b0);
    chk("latency", lat, 32'h2);
    chk("trunk loop", g_ports, 8'hF8);
    frame(3'h3, BC, 1'b0, 12'h000, 1'b0);
    chk("flood", g_ports[7:3], 5'h1E);
    chk("flood member", $countones(g_ports[2:0]), 32'h1);
    frame(3'h4, {8'h02, 40'h0}, 1'b0, 12'h000, 1'b0);
    first = g_ports;
    chk("uc member", $countones(g_ports[2:0]), 32'h1);
    chk("uc rest", g_ports[7:3], 5'h00);
    frame(3'h4, {8'h02, 40'h0}, 1'b0, 12'h000, 1'b0);
    chk("uc same", g_ports, first);
    wr(tvf_pkg::OFF_TRUNK, 32'h0);
    $display("trunk done");
  endtask
  task automatic t_group();
    wr(tvf_pkg::OFF_WG_SEL, 32'h0);
    wr(tvf_pkg::OFF_WG_PORTS, 32'h18);
    wr(tvf_pkg::OFF_WG_SEL, 32'h1);
    wr(tvf_pkg::OFF_WG_PORTS, 32'h30);
    frame(3'h4, BC, 1'b0, 12'h000, 1'b0);
    chk("wg union", g_ports, 8'h28);
    frame(3'h3, BC, 1'b0, 12'h000, 1'b0);
    chk("wg bcast", g_ports, 8'h10);
    frame(3'h3, {8'h02, 40'h0}, 1'b0, 12'h000, 1'b0);
    chk("wg ucast", g_drop, 1'b1);
    $display("workgroup done");
  endtask
  task automatic t_vlan();
    wr(tvf_pkg::OFF_CTRL, 32'h1);
    wr(tvf_pkg::OFF_VL_SEL, 32'h0);
    wr(tvf_pkg::OFF_VL_ID, 32'h1005);
    wr(tvf_pkg::OFF_VL_PORTS, 32'h4A);
    wr(tvf_pkg::OFF_ACCESS, 32'h40);
    frame(3'h3, BC, 1'b1, 12'h005, 1'b0);
    chk("members", g_ports, 8'h42);
    chk("strip", g_strip, 8'h40);
    chk("fcs", g_fcs, 1'b1);
    frame(3'h3, BC, 1'b1, 12'h009, 1'b0);
    chk("bad vid", g_drop, 1'b1);
    frame(3'h0, BC, 1'b1, 12'h005, 1'b0);
    chk("non member", g_drop, 1'b1);
    frame(3'h1, BC, 1'b0, 12'h000, 1'b0);
    chk("pvid one", g_drop, 1'b1);
    wr(tvf_pkg::OFF_PV_SEL, 32'h1);
    wr(tvf_pkg::OFF_PV_ID, 32'h005);
    wr(tvf_pkg::OFF_STP_FWD, 32'hF7);
    frame(3'h1, BC, 1'b0, 12'h000, 1'b0);
    chk("pvid stp", g_ports, 8'h40);
    chk("no fcs", g_fcs, 1'b0);
    $display("vlan done");
  endtask
  task automatic t_reg();
    wr(tvf_pkg::OFF_GVRP, 32'h04);
    wr(tvf_pkg::OFF_BL_SEL, 32'h0);
    wr(tvf_pkg::OFF_BL_ID, 32'h1007);
    frame(3'h0, BC, 1'b1, 12'h005, 1'b1);
    frame(3'h0, BC, 1'b1, 12'h005, 1'b0);
    chk("reg off", g_drop, 1'b1);
    frame(3'h2, BC, 1'b1, 12'h005, 1'b1);
    frame(3'h2, BC, 1'b1, 12'h005, 1'b0);
    chk("reg join", g_ports, 8'h42);
    frame(3'h2, BC, 1'b1, 12'h007, 1'b1);
    frame(3'h2, BC, 1'b1, 12'h007, 1'b0);
    chk("blocked", g_drop, 1'b1);
    wr(tvf_pkg::OFF_VL_SEL, 32'h1F);
    rdc("blocked slot", tvf_pkg::OFF_VL_ID, 32'h0);
    frame(3'h2, BC, 1'b1, 12'h009, 1'b1);
    rdc("dyn slot", tvf_pkg::OFF_VL_ID, 32'h0000_3009);
    $display("registration done");
  endtask
  task automatic t_erase();
    wr(tvf_pkg::OFF_CTRL, 32'h2);
    rdc("erase mode", tvf_pkg::OFF_CTRL, 32'h0);
    rdc("erase pvid", tvf_pkg::OFF_PV_ID, 32'h1);
    rdc("erase access", tvf_pkg::OFF_ACCESS, 32'h0);
    frame(3'h3, BC, 1'b0, 12'h000, 1'b0);
    chk("erase wg", g_ports, 8'hF7);
    $display("erase done");
  endtask
  // two ticks of age; one tick at most passes before the first lookup
  task automatic t_age();
    wr(tvf_pkg::OFF_AGE, 32'h2);
    wr(tvf_pkg::OFF_TRUNK, 32'h04);
    frame(3'h5, BC, 1'b0, 12'h000, 1'b0);
    frame(3'h6, {8'h02, 40'h5}, 1'b0, 12'h000, 1'b0);
    chk("known", g_ports, 8'h20);
    frame(3'h2, BC, 1'b0, 12'h000, 1'b0);
    repeat (12) @(posedge pclk);
    frame(3'h6, {8'h02, 40'h5}, 1'b0, 12'h000, 1'b0);
    chk("aged out", g_ports, 8'hBF);
    frame(3'h6, {8'h02, 40'h2}, 1'b0, 12'h000, 1'b0);
    chk("trunk kept", g_ports, 8'h04);
    $display("aging done");
  endtask
  initial begin
    #1000000;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_trunk();
    t_group();
    t_vlan();
    t_reg();
    t_erase();
    t_age();
    end_of_test();
  end
endmodule // tvf_filter_tb_top
`default_nettype wire
